// ==== rtl/mpr_pin_supervisor.sv ====
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Secondary reset stays low while manual reset input is low.
// - After manual reset rises, secondary reset holds for the hold interval.
// - Primary reset pin low while supply is low, then held for hold interval.
// - Primary reset pin is open-drain; external low resets the device internally.
// - Secondary reset low on aux or supply low, manual reset, or primary reset.
// - Secondary reset held for hold interval after every source clears.
// - Fan shutdown request pin is driven low to ask for fan off.
// - High test pin selects connectivity test; else it carries fan speed.
// - In connectivity test the address pin becomes the test result output.
// - Negative second diode pin is analog input or open-drain digital pin.
// - In digital mode the over-temperature pin is driven low on set point.
// - External low on over-temperature pin sets status and forces full fan.
// - Positive second diode pin can be a polarity-selectable input setting bit 4.
// - Input status bit clears only on status read while input is inactive.
// - Address pin sampled once at power-up, later changes ignored.
// - Interrupt pin signals trip only when config bit 1 set; off after reset.
// - Slave address is 01011 above two bits from the address pin.
// - Status also readable through a mirror at 4Ch.
module mpr_pin_supervisor
  import mpr_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitors and manual reset
  input wire logic supply_low,
  input wire logic aux_voltage_monitor_low,
  input wire logic manual_reset_n,
  // Reset pins
  input wire logic primary_reset_n_in,
  output logic primary_reset_n_out,
  output logic primary_reset_n_oe,
  output logic secondary_reset_n_out,
  output logic secondary_reset_n_oe,
  output logic core_reset_n,
  // Fan pins
  output logic fan_off_n_out,
  output logic fan_off_n_oe,
  output logic [7:0] fan_speed_out,
  output logic fan_speed_oe,
  input wire logic connectivity_test_enable,
  // Second diode pins
  input wire logic second_diode_neg_in,
  output logic second_diode_neg_out,
  output logic second_diode_neg_oe,
  input wire logic second_diode_pos_in,
  output logic diode2_analog,
  // Address pin
  input wire logic addr_sel_high,
  input wire logic addr_sel_low,
  output logic connectivity_test_out,
  output logic connectivity_test_oe,
  output logic [6:0] slave_addr,
  // Interrupt pin and core events
  input wire logic setpoint_exceeded,
  input wire logic trip_violation,
  output logic int_n_out,
  output logic int_n_oe
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  mpr_pins_s raw, meta_q, pins_q;
  assign raw = '{manual_reset_n: manual_reset_n, supply_low: supply_low,
                 aux_voltage_monitor_low: aux_voltage_monitor_low,
                 primary_reset_n: primary_reset_n_in, second_diode_neg: second_diode_neg_in,
                 second_diode_pos: second_diode_pos_in,
                 connectivity_test_enable: connectivity_test_enable,
                 addr_sel_high: addr_sel_high, addr_sel_low: addr_sel_low};

  genvar gi;
  generate
    for (gi = 0; gi < $bits(mpr_pins_s); gi++) begin : g_sync
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          meta_q[gi] <= 1'b0;
          pins_q[gi] <= 1'b0;
        end else if (ce) begin
          meta_q[gi] <= raw[gi];
          pins_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Reset generators
  // ==========================================================
  logic pri_active, sec_active, sec_src;

  mpr_reset_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_primary (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .src_active(pins_q.supply_low),
    .reset_active(pri_active)
  );

  // Pin level, not own drive, so an external low also counts
  assign sec_src = pins_q.supply_low || pins_q.aux_voltage_monitor_low
                   || !pins_q.manual_reset_n || !pins_q.primary_reset_n;

  mpr_reset_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_secondary (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .src_active(sec_src),
    .reset_active(sec_active)
  );

  assign primary_reset_n_out = 1'b0;
  assign primary_reset_n_oe = pri_active;
  assign secondary_reset_n_out = 1'b0;
  assign secondary_reset_n_oe = sec_active;
  assign core_reset_n = pins_q.primary_reset_n;

  // ==========================================================
  // Registers and pin state
  // ==========================================================
  mpr_cfg_s cfg_q, cfg_d;
  logic [7:0] dac_q, dac_d, fan_q, fan_d;
  logic stat_gpi_q, stat_gpi_d, stat_therm_q, stat_therm_d;
  logic therm_oe_q, therm_oe_d, therm_p1_q, therm_p2_q;
  logic [1:0] add_q, add_d, add_wait_q, add_wait_d;
  logic add_done_q, add_done_d, test_out_q, test_out_d;
  logic [31:0] prdata_q, prdata_d;
  logic setup, access, wr_en, rd_status, hit, gpi_active, ext_therm;

  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a, input mpr_cfg_s c,
                                            input logic [7:0] dac, input logic [6:0] sa,
                                            input logic sg, input logic st, input mpr_pins_s p);
    logic [31:0] r;
    r = '0;
    case (a)
      REG_CFG: r[7:0] = c;
      REG_STATUS, REG_STATUS_MIRROR: begin
        r[STAT_GPI_BIT] = sg;
        r[STAT_THERM_BIT] = st;
      end
      REG_SLAVE_ADDR: r[6:0] = sa;
      REG_PIN_LEVELS: r[8:0] = p;
      REG_FAN_DAC: r[7:0] = dac;
      default: r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    hit = (paddr == REG_CFG) || (paddr == REG_STATUS) || (paddr == REG_STATUS_MIRROR)
          || (paddr == REG_SLAVE_ADDR) || (paddr == REG_PIN_LEVELS) || (paddr == REG_FAN_DAC);
    setup = psel && !penable;
    access = psel && penable;
    wr_en = access && pwrite && hit;
    rd_status = access && !pwrite && ((paddr == REG_STATUS) || (paddr == REG_STATUS_MIRROR));
    gpi_active = cfg_q.diode2_digital
                 && (pins_q.second_diode_pos == cfg_q.gpi_active_high);
    // No own drive for three cycles, so the sampled low is not our echo
    ext_therm = cfg_q.diode2_digital && !pins_q.second_diode_neg
                && !therm_oe_q && !therm_p1_q && !therm_p2_q;

    cfg_d = cfg_q;
    dac_d = dac_q;
    if (wr_en && paddr == REG_CFG) begin
      cfg_d = mpr_cfg_s'(pwdata[7:0]);
      cfg_d.rsvd = '0;
    end
    if (wr_en && paddr == REG_FAN_DAC) begin
      dac_d = pwdata[7:0];
    end

    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = read_mux(paddr, cfg_q, dac_q, slave_addr, stat_gpi_q, stat_therm_q, pins_q);
    end

    // Only bits already reported are cleared, so a set is never lost
    stat_gpi_d = gpi_active || (stat_gpi_q && !(rd_status && prdata_q[STAT_GPI_BIT]));
    stat_therm_d = ext_therm || (stat_therm_q && !(rd_status && prdata_q[STAT_THERM_BIT]));

    therm_oe_d = cfg_q.diode2_digital && setpoint_exceeded;
    fan_d = ext_therm ? FAN_FULL : dac_q;
    test_out_d = ~&pins_q;

    add_wait_d = add_wait_q;
    add_d = add_q;
    add_done_d = add_done_q;
    if (!add_done_q) begin
      if (add_wait_q == 2'h2) begin
        add_done_d = 1'b1;
        add_d = pins_q.addr_sel_low ? ADD_PIN_GND : (pins_q.addr_sel_high ? ADD_PIN_VCC : ADD_PIN_OPEN);
      end else begin
        add_wait_d = add_wait_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= mpr_cfg_s'(CFG_RESET);
      dac_q <= FAN_DAC_RESET;
      fan_q <= FAN_DAC_RESET;
      stat_gpi_q <= 1'b0;
      stat_therm_q <= 1'b0;
      therm_oe_q <= 1'b0;
      therm_p1_q <= 1'b0;
      therm_p2_q <= 1'b0;
      add_q <= ADD_PIN_OPEN;
      add_wait_q <= 2'h0;
      add_done_q <= 1'b0;
      test_out_q <= 1'b0;
      prdata_q <= '0;
    end else if (ce) begin
      cfg_q <= cfg_d;
      dac_q <= dac_d;
      fan_q <= fan_d;
      stat_gpi_q <= stat_gpi_d;
      stat_therm_q <= stat_therm_d;
      therm_oe_q <= therm_oe_d;
      therm_p1_q <= therm_oe_q;
      therm_p2_q <= therm_p1_q;
      add_q <= add_d;
      add_wait_q <= add_wait_d;
      add_done_q <= add_done_d;
      test_out_q <= test_out_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_q;
  assign slave_addr = {SLAVE_ADDR_UPPER, add_q};
  assign fan_off_n_out = 1'b0;
  assign fan_off_n_oe = cfg_q.fan_off_req;
  assign fan_speed_out = fan_q;
  assign fan_speed_oe = !pins_q.connectivity_test_enable;
  assign connectivity_test_out = test_out_q;
  assign connectivity_test_oe = pins_q.connectivity_test_enable;
  assign diode2_analog = !cfg_q.diode2_digital;
  assign second_diode_neg_out = 1'b0;
  assign second_diode_neg_oe = therm_oe_q;
  assign int_n_out = 1'b0;
  assign int_n_oe = cfg_q.int_enable && trip_violation;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_mr_holds;
    @(posedge clock) disable iff (!nrst)
    !pins_q.manual_reset_n |-> secondary_reset_n_oe;
  endproperty
  a_mr_holds: assert property (p_mr_holds) else $error("manual reset not seen");

  property p_supply_primary;
    @(posedge clock) disable iff (!nrst)
    pins_q.supply_low |-> primary_reset_n_oe && secondary_reset_n_oe;
  endproperty
  a_supply_primary: assert property (p_supply_primary) else $error("supply low missed");

  property p_ext_primary;
    @(posedge clock) disable iff (!nrst)
    !pins_q.primary_reset_n |-> !core_reset_n && secondary_reset_n_oe;
  endproperty
  a_ext_primary: assert property (p_ext_primary) else $error("external reset missed");

  property p_aux_secondary;
    @(posedge clock) disable iff (!nrst)
    pins_q.aux_voltage_monitor_low |-> secondary_reset_n_oe;
  endproperty
  a_aux_secondary: assert property (p_aux_secondary) else $error("aux low missed");

  property p_fan_off;
    @(posedge clock) disable iff (!nrst)
    (ce && wr_en && paddr == REG_CFG) |=> fan_off_n_oe == $past(pwdata[3]);
  endproperty
  a_fan_off: assert property (p_fan_off) else $error("fan off not written");

  property p_test_mode;
    @(posedge clock) disable iff (!nrst)
    pins_q.connectivity_test_enable |-> !fan_speed_oe && connectivity_test_oe;
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("test mode pins wrong");

  property p_therm_drive;
    @(posedge clock) disable iff (!nrst)
    (ce && cfg_q.diode2_digital && setpoint_exceeded) |=> second_diode_neg_oe;
  endproperty
  a_therm_drive: assert property (p_therm_drive) else $error("therm not driven");

  property p_ext_therm;
    @(posedge clock) disable iff (!nrst)
    (ce && ext_therm) |=> stat_therm_q && fan_speed_out == FAN_FULL;
  endproperty
  a_ext_therm: assert property (p_ext_therm) else $error("therm input ignored");

  property p_gpi_sticky;
    @(posedge clock) disable iff (!nrst)
    (ce && stat_gpi_q && !rd_status) |=> stat_gpi_q;
  endproperty
  a_gpi_sticky: assert property (p_gpi_sticky) else $error("gpi cleared without read");

  property p_addr_frozen;
    @(posedge clock) disable iff (!nrst)
    add_done_q |=> $stable(slave_addr) && slave_addr[6:2] == SLAVE_ADDR_UPPER;
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address changed");

  property p_int_gate;
    @(posedge clock) disable iff (!nrst)
    int_n_oe |-> cfg_q.int_enable && trip_violation;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt not gated");

  c_gpi_read: cover property (@(posedge clock) disable iff (!nrst) stat_gpi_q && rd_status ##1 !stat_gpi_q);
  c_ext_therm: cover property (@(posedge clock) disable iff (!nrst) ext_therm);
  c_sec_release: cover property (@(posedge clock) disable iff (!nrst) $fell(secondary_reset_n_oe));

endmodule // mpr_pin_supervisor
`default_nettype wire

// ==== inc/mpr_pkg.sv ====
package mpr_pkg;

  // ==========================================================
  // Register map, byte addresses on the APB
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SLAVE_ADDR = 8'h08;
  localparam logic [7:0] REG_PIN_LEVELS = 8'h0C;
  localparam logic [7:0] REG_FAN_DAC = 8'h10;
  localparam logic [7:0] REG_STATUS_MIRROR = 8'h4C;

  // ==========================================================
  // Fields and reset values
  // ==========================================================
  localparam int STAT_GPI_BIT = 4;
  localparam int STAT_THERM_BIT = 5;
  localparam logic [4:0] SLAVE_ADDR_UPPER = 5'h0B;
  localparam logic [1:0] ADD_PIN_GND = 2'h2;
  localparam logic [1:0] ADD_PIN_OPEN = 2'h0;
  localparam logic [1:0] ADD_PIN_VCC = 2'h1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] FAN_DAC_RESET = 8'h00;
  localparam logic [7:0] FAN_FULL = 8'hFF;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLOCK_MHZ = 200;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [3:0] rsvd;
    logic fan_off_req;
    logic gpi_active_high;
    logic int_enable;
    logic diode2_digital;
  } mpr_cfg_s;

  typedef struct packed {
    logic manual_reset_n;
    logic supply_low;
    logic aux_voltage_monitor_low;
    logic primary_reset_n;
    logic second_diode_neg;
    logic second_diode_pos;
    logic connectivity_test_enable;
    logic addr_sel_high;
    logic addr_sel_low;
  } mpr_pins_s;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_ACTIVE = 3'b010,
    RS_HOLD = 3'b100
  } mpr_rst_e;

endpackage

// ==== rtl/mpr_reset_stretch.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpr_reset_stretch
  import mpr_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // Reset source and stretched result
  input wire logic src_active,
  output logic reset_active
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  mpr_rst_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;

  // ==========================================================
  // Stretch state machine
  // ==========================================================
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RS_IDLE: begin
        if (src_active) begin
          state_d = RS_ACTIVE;
        end
      end
      RS_ACTIVE: begin
        if (!src_active) begin
          state_d = RS_HOLD;
          cnt_d = '0;
        end
      end
      RS_HOLD: begin
        if (src_active) begin
          state_d = RS_ACTIVE;
        end else if (cnt_q == CW'(HOLD_CYCLES - 1)) begin
          state_d = RS_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = RS_ACTIVE;
      end
    endcase
  end

  // Power-up counts as a source, so the output starts asserted
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= RS_ACTIVE;
      cnt_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Source passes straight through so assertion has no lag
  assign reset_active = src_active || (state_q != RS_IDLE);

  // ==========================================================
  // Checks
  // ==========================================================
  property p_release_after_hold;
    @(posedge clock) disable iff (!nrst)
    $fell(reset_active) |-> $past(state_q) == RS_HOLD && $past(cnt_q) == CW'(HOLD_CYCLES - 1);
  endproperty
  a_release_after_hold: assert property (p_release_after_hold) else $error("reset released early");

  property p_restart;
    @(posedge clock) disable iff (!nrst)
    (state_q == RS_HOLD && src_active && ce) |=> state_q == RS_ACTIVE && reset_active;
  endproperty
  a_restart: assert property (p_restart) else $error("hold not restarted");

  property p_src_holds;
    @(posedge clock) disable iff (!nrst)
    src_active |-> reset_active;
  endproperty
  a_src_holds: assert property (p_src_holds) else $error("source not passed");

  c_hold_done: cover property (@(posedge clock) disable iff (!nrst)
    state_q == RS_HOLD ##1 state_q == RS_IDLE);

endmodule // mpr_reset_stretch
`default_nettype wire

// ==== verification/mpr_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpr_board_model (
  // Device pin drives
  input wire logic primary_reset_n_oe,
  input wire logic second_diode_neg_oe,
  input wire logic fan_off_n_oe,
  // Board side pull-downs
  input wire logic ext_reset_pull,
  input wire logic ext_therm_pull,
  // Resolved nets
  output logic primary_reset_n_pin,
  output logic second_diode_neg_pin,
  output logic sys_aux_reset_n,
  output logic fan_may_run
);
  // ==========================================================
  // Open-drain nets, pulled up on the board
  // ==========================================================
  assign primary_reset_n_pin = ~(primary_reset_n_oe | ext_reset_pull);
  // Board drive goes in through a diode, so aux reset sees the device only
  assign sys_aux_reset_n = ~primary_reset_n_oe;
  assign second_diode_neg_pin = ~(second_diode_neg_oe | ext_therm_pull);
  assign fan_may_run = ~fan_off_n_oe;
endmodule // mpr_board_model
`default_nettype wire

// ==== verification/mpr_pin_supervisor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpr_pin_supervisor_tb;
  import mpr_pkg::*;
  // Short hold keeps the run brief
  localparam int H = 4;
  logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, supply_low = 1'b0, aux_low = 1'b0, manual_reset_n = 1'b1;
  logic test_en = 1'b0, pos_in = 1'b0, a_hi = 1'b0, a_lo = 1'b1, setpoint = 1'b0, trip = 1'b0, ce = 1'b1;
  logic p_lo, s_lo, f_lo, n_lo, i_lo;
  logic ext_reset_pull = 1'b0, ext_therm_pull = 1'b0, prim_pin, neg_pin, aux_rst_n, fan_run;
  logic prim_oe, sec_oe, core_reset_n, fan_off_oe, fan_oe, neg_oe, d2_analog, ct_out, ct_oe, int_oe;
  logic [7:0] fan_speed;
  logic [6:0] slave_addr;
  int fails = 0, samples_checked = 0, n;

  always #2.5 clock = ~clock;

  mpr_pin_supervisor #(.HOLD_CYCLES(H)) dut (.clock(clock), .nrst(nrst), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
    .aux_voltage_monitor_low(aux_low), .manual_reset_n(manual_reset_n),
    .primary_reset_n_in(prim_pin), .primary_reset_n_out(p_lo), .primary_reset_n_oe(prim_oe),
    .secondary_reset_n_out(s_lo), .secondary_reset_n_oe(sec_oe), .core_reset_n(core_reset_n),
    .fan_off_n_out(f_lo), .fan_off_n_oe(fan_off_oe), .fan_speed_out(fan_speed), .fan_speed_oe(fan_oe),
    .connectivity_test_enable(test_en), .second_diode_neg_in(neg_pin), .second_diode_neg_out(n_lo),
    .second_diode_neg_oe(neg_oe), .second_diode_pos_in(pos_in), .diode2_analog(d2_analog),
    .addr_sel_high(a_hi), .addr_sel_low(a_lo), .connectivity_test_out(ct_out),
    .connectivity_test_oe(ct_oe), .slave_addr(slave_addr), .setpoint_exceeded(setpoint),
    .trip_violation(trip), .int_n_out(i_lo), .int_n_oe(int_oe));

  mpr_board_model board (.primary_reset_n_oe(prim_oe), .second_diode_neg_oe(neg_oe),
    .fan_off_n_oe(fan_off_oe), .ext_reset_pull(ext_reset_pull), .ext_therm_pull(ext_therm_pull),
    .primary_reset_n_pin(prim_pin), .second_diode_neg_pin(neg_pin), .sys_aux_reset_n(aux_rst_n),
    .fan_may_run(fan_run));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic look(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk($sformatf("write error %h", a), 0, er);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk($sformatf("read %h", a), exp, rd);
    chk($sformatf("read error %h", a), 0, er);
  endtask

  // Cycles until the chosen reset output lets go
  task automatic hold_len(input logic sec);
    n = 0;
    while (((sec ? sec_oe : prim_oe) === 1'b1) && n < 60) begin
      @(negedge clock);
      n++;
    end
  endtask

  // Two sync edges plus H+1 held cycles, seen at the following falling edge
  task automatic hold_ok(input string what);
    chk(what, H + 4, n);
  endtask

  task automatic fin(input string t);
    $display("test %s ended, %0d mismatches so far", t, fails);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    look(11);
    chk("primary in reset", 1, prim_oe);
    chk("secondary in reset", 1, sec_oe);
    chk("int in reset", 0, int_oe);
    chk("drive levels", 0, {p_lo, s_lo, f_lo, n_lo, i_lo});
    @(posedge clock);
    nrst <= 1'b1;
    hold_len(1'b1);
    chk("secondary release", 1, n < 60);
    chk("slave address", {SLAVE_ADDR_UPPER, 2'h2}, slave_addr);
    @(posedge clock);
    a_lo <= 1'b0;
    a_hi <= 1'b1;
    trip <= 1'b1;
    look(6);
    chk("slave address kept", {SLAVE_ADDR_UPPER, 2'h2}, slave_addr);
    chk("int disabled", 0, int_oe);
    chk("analog mode", 1, d2_analog);
    rdchk(REG_SLAVE_ADDR, {25'h0, SLAVE_ADDR_UPPER, 2'h2});
    rdchk(REG_CFG, {24'h0, CFG_RESET});
    fin("defaults");
    @(posedge clock);
    manual_reset_n <= 1'b0;
    look(6);
    chk("secondary manual", 1, sec_oe);
    chk("primary manual", 0, prim_oe);
    @(posedge clock);
    manual_reset_n <= 1'b1;
    hold_len(1'b1);
    hold_ok("manual hold");
    @(posedge clock);
    manual_reset_n <= 1'b0;
    @(posedge clock);
    manual_reset_n <= 1'b1;
    repeat (H) @(posedge clock);
    manual_reset_n <= 1'b0;
    @(posedge clock);
    manual_reset_n <= 1'b1;
    hold_len(1'b1);
    hold_ok("restarted hold");
    fin("manual");
    @(posedge clock);
    supply_low <= 1'b1;
    look(6);
    chk("primary supply", 1, prim_oe);
    chk("secondary supply", 1, sec_oe);
    chk("aux reset", 0, aux_rst_n);
    @(posedge clock);
    supply_low <= 1'b0;
    hold_len(1'b0);
    hold_ok("primary hold");
    hold_len(1'b1);
    @(posedge clock);
    aux_low <= 1'b1;
    look(6);
    chk("secondary aux", 1, sec_oe);
    chk("primary aux", 0, prim_oe);
    @(posedge clock);
    aux_low <= 1'b0;
    hold_len(1'b1);
    hold_ok("aux hold");
    @(posedge clock);
    ext_reset_pull <= 1'b1;
    look(6);
    chk("core reset", 0, core_reset_n);
    chk("secondary pin", 1, sec_oe);
    chk("aux isolated", 1, aux_rst_n);
    @(posedge clock);
    ext_reset_pull <= 1'b0;
    hold_len(1'b1);
    hold_ok("pin hold");
    fin("resets");
    wr(REG_CFG, 32'h0000_00FF);
    rdchk(REG_CFG, 32'h0000_000F);
    look(2);
    chk("fan off", 1, fan_off_oe);
    chk("fan may run", 0, fan_run);
    chk("int enabled", 1, int_oe);
    wr(REG_CFG, 32'h0);
    look(2);
    chk("fan on", 0, fan_off_oe);
    chk("int off", 0, int_oe);
    @(posedge clock);
    test_en <= 1'b1;
    look(5);
    chk("fan pin in test", 0, fan_oe);
    chk("test out drive", 1, ct_oe);
    chk("test out", 1, ct_out);
    @(posedge clock);
    test_en <= 1'b0;
    look(5);
    chk("fan pin back", 1, fan_oe);
    chk("test out off", 0, ct_oe);
    fin("config");
    wr(REG_FAN_DAC, 32'h0000_005A);
    rdchk(REG_FAN_DAC, 32'h0000_005A);
    wr(REG_CFG, 32'h0000_0005);
    look(2);
    chk("fan code", 8'h5A, fan_speed);
    chk("digital mode", 0, d2_analog);
    @(posedge clock);
    pos_in <= 1'b1;
    ext_therm_pull <= 1'b1;
    look(6);
    chk("fan full", FAN_FULL, fan_speed);
    rdchk(REG_STATUS, 32'h0000_0030);
    rdchk(REG_STATUS, 32'h0000_0030);
    @(posedge clock);
    pos_in <= 1'b0;
    ext_therm_pull <= 1'b0;
    look(5);
    rdchk(REG_STATUS_MIRROR, 32'h0000_0030);
    rdchk(REG_STATUS, 32'h0);
    wr(REG_CFG, 32'h0000_0001);
    look(4);
    rdchk(REG_STATUS, 32'h0000_0010);
    @(posedge clock);
    setpoint <= 1'b1;
    pos_in <= 1'b1;
    look(5);
    chk("over-temp drive", 1, neg_oe);
    rdchk(REG_STATUS_MIRROR, 32'h0000_0010);
    rdchk(REG_STATUS, 32'h0);
    @(posedge clock);
    setpoint <= 1'b0;
    fin("status");
    // Frozen clock enable must drop the write
    ce <= 1'b0;
    wr(REG_FAN_DAC, 32'h0000_0033);
    ce <= 1'b1;
    rdchk(REG_FAN_DAC, 32'h0000_005A);
    apb(1'b0, 8'h20, '0);
    chk("unmapped error", 1, er);
    chk("unmapped data", 0, rd);
    wr(REG_SLAVE_ADDR, 32'h0);
    rdchk(REG_SLAVE_ADDR, {25'h0, SLAVE_ADDR_UPPER, 2'h2});
    @(posedge clock);
    nrst <= 1'b0;
    a_hi <= 1'b0;
    look(3);
    @(posedge clock);
    nrst <= 1'b1;
    hold_len(1'b1);
    chk("open address", {SLAVE_ADDR_UPPER, ADD_PIN_OPEN}, slave_addr);
    fin("bus and second reset");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule // mpr_pin_supervisor_tb
`default_nettype wire
